// ==== design/hht_pkg.sv ====
// Package for the host handshake and trigger control block.
// Assumes a single 20 MHz clock; all timing counts are in that clock.
package hht_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int ACCESS_TIME_NS = 150;
   localparam int ACCESS_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ZW_BUSY_TIME_NS = 100;
   localparam int ZW_BUSY_CYCLES = (ZW_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   // Configuration register 1 bit positions
   localparam int CFG1_EXT_START_BIT = 7;
   localparam int CFG1_SUBSYSTEM_FLAG_IN_BIT = 8;
   // Reset values and host mode strap codes
   localparam logic RST_READY = 1'b1;
   localparam logic RST_IO_BUFFER_ENABLE_OUT = 1'b1;
   localparam logic STRAP_BUFFERED = 1'b0;
   localparam logic STRAP_TRANSPARENT = 1'b1;

   // Operating modes of the terminal
   typedef enum logic [2:0] {
      HHT_MODE_RT,
      HHT_MODE_BC,
      HHT_MODE_BC_ENH,
      HHT_MODE_WORD_MON,
      HHT_MODE_MSG_MON
   } hht_mode_t;

   // Host access handshake states
   typedef enum logic [1:0] {
      HHT_IDLE,
      HHT_ACCESS,
      HHT_DONE,
      HHT_RELEASE
   } hht_hs_t;

   // Host request bundle
   typedef struct packed {
      logic strobe_n;
      logic read;
      logic zero_wait;
   } hht_host_req_t;

   // Trigger events to the protocol core
   typedef struct packed {
      logic bc_start;
      logic wtg_advance;
      logic mon_start;
   } hht_trig_t;
endpackage : hht_pkg

// ==== design/hht_edge_det.sv ====
// Rising edge detector on a synchronous input.
// Assumes the input is already synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module hht_edge_det
   import hht_pkg::*;
(
   input wire logic i_clk,     // Clock
   input wire logic i_reset_n, // Async reset, low
   input wire logic i_level,   // Level watched
   output logic o_rise         // One-cycle pulse on rise
);
   typedef struct packed {
      logic prev;
      logic rise;
   } hht_ed_st_t;
   hht_ed_st_t st_r;
   hht_ed_st_t st_nxt;

   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = i_level;
      st_nxt.rise = i_level & ~st_r.prev;
   end

   // State register; prev resets high so a level high at release is no edge
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= '{prev: 1'b1, rise: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rise = st_r.rise;
endmodule : hht_edge_det
`default_nettype wire

// ==== design/hht_host_ctrl.sv ====
// Host handshake and trigger control: ready handshake, I/O enable,
// host mode strap, subsystem flag and external trigger handling.
// Assumes host pins are synchronous to i_clk and the host keeps strobe low
// until ready goes low in nonzero-wait mode.
`timescale 1ns/1ps
`default_nettype none
module hht_host_ctrl
   import hht_pkg::*;
#(
   parameter int ACCESS_CNT = ACCESS_CYCLES,  // Internal access length
   parameter int ZW_BUSY_CNT = ZW_BUSY_CYCLES // Zero-wait busy length
)
(
   input wire logic i_clk,                  // 20 MHz clock
   input wire logic i_reset_n,              // Async reset, low
   input wire logic i_host_port_mode_strap, // 0 buffered, 1 transparent
   input wire hht_host_req_t i_host_req,    // Strobe, direction, wait mode
   input wire logic [15:0] i_rd_data,       // Internal read data
   input wire hht_mode_t i_mode,            // Terminal operating mode
   input wire logic [15:0] i_cfg1_wr_data,  // Config reg 1 write value
   input wire logic i_cfg1_wr,              // Config reg 1 write strobe
   input wire logic i_subsystem_flag_in_n,  // Flag input, active low
   input wire logic i_wait_trigger_instr,   // Executing wait-trigger
   output logic o_host_ready_out_n,         // Ready handshake, low asserted
   output logic o_io_buffer_enable_out_n,   // I/O enable, low asserted
   output logic [15:0] o_host_data,         // Data to host
   output logic o_store_strobe,             // Write data store pulse
   output logic o_transparent,              // Host mode is transparent
   output logic o_cfg1_subsystem_flag_in,              // Bit 8 read-back
   output logic o_status_subsystem_flag_in,            // Transmitted status flag bit
   output hht_trig_t o_trig                 // Trigger events
);
   // The shared pin: trigger in BC, enhanced BC and word monitor, flag in RT
   wire logic trig_level = i_subsystem_flag_in_n;
   logic trig_rise;

   typedef struct packed {
      hht_hs_t hs;
      logic [CNT_W-1:0] cnt;
      logic ready_n;
      logic io_buffer_enable_out_n;
      logic [15:0] data;
      logic store;
      logic transparent;
      logic strap_taken;
      logic cfg1_ext_start;
      logic cfg1_subsystem_flag_in;
      logic status_subsystem_flag_in;
      logic wtg_pending;
      hht_trig_t trig;
      logic zw;
   } hht_st_t;
   hht_st_t st_r;
   hht_st_t st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Trigger edge detect
   hht_edge_det u_trig_edge (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_level(trig_level),
      .o_rise(trig_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.store = 1'b0;
      st_nxt.trig = '0;

      // Strap caught once after reset release
      if (!st_r.strap_taken) begin
         st_nxt.transparent = (i_host_port_mode_strap == STRAP_TRANSPARENT);
         st_nxt.strap_taken = 1'b1;
      end

      // Config reg 1 fields hold the written value only
      if (i_cfg1_wr) begin
         st_nxt.cfg1_ext_start = i_cfg1_wr_data[CFG1_EXT_START_BIT];
         st_nxt.cfg1_subsystem_flag_in = i_cfg1_wr_data[CFG1_SUBSYSTEM_FLAG_IN_BIT];
      end

      // Status flag: bit 8 low means set, one means cleared; low pin sets it anyway in RT
      st_nxt.status_subsystem_flag_in = ~st_nxt.cfg1_subsystem_flag_in
         | ((i_mode == HHT_MODE_RT) & ~i_subsystem_flag_in_n);

      // Trigger events per mode; message monitor ignores the pin
      unique case (i_mode)
         HHT_MODE_BC: begin
            st_nxt.trig.bc_start = trig_rise & st_r.cfg1_ext_start;
            st_nxt.wtg_pending = 1'b0;
         end
         HHT_MODE_BC_ENH: begin
            // Stall on the instruction until the edge comes
            if (i_wait_trigger_instr && trig_rise) begin
               st_nxt.trig.wtg_advance = 1'b1;
            end
            st_nxt.wtg_pending = i_wait_trigger_instr & ~trig_rise;
         end
         HHT_MODE_WORD_MON: begin
            st_nxt.trig.mon_start = trig_rise & st_r.cfg1_ext_start;
            st_nxt.wtg_pending = 1'b0;
         end
         HHT_MODE_MSG_MON: begin
            st_nxt.wtg_pending = 1'b0;
         end
         HHT_MODE_RT: begin
            st_nxt.wtg_pending = 1'b0;
         end
         default: begin
            // Unused mode codes act on nothing
            st_nxt.wtg_pending = 1'b0;
         end
      endcase

      // Host access handshake
      unique case (st_r.hs)
         HHT_IDLE: begin
            st_nxt.ready_n = RST_READY;
            st_nxt.io_buffer_enable_out_n = RST_IO_BUFFER_ENABLE_OUT;
            if (!i_host_req.strobe_n) begin
               st_nxt.hs = HHT_ACCESS;
               st_nxt.zw = i_host_req.zero_wait & ~st_r.transparent;
               st_nxt.io_buffer_enable_out_n = 1'b0;
               st_nxt.cnt = '0;
               if (i_host_req.zero_wait && !st_r.transparent) begin
                  st_nxt.ready_n = 1'b0;
               end
            end
         end
         HHT_ACCESS: begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.zw) begin
               if (st_r.cnt == CNT_W'(ZW_BUSY_CNT - 1)) begin
                  st_nxt.hs = HHT_RELEASE;
                  st_nxt.io_buffer_enable_out_n = 1'b1;
                  st_nxt.store = ~i_host_req.read;
                  st_nxt.data = i_rd_data;
               end
            end else if (st_r.cnt == CNT_W'(ACCESS_CNT - 1)) begin
               st_nxt.hs = HHT_DONE;
               st_nxt.io_buffer_enable_out_n = 1'b1;
               st_nxt.ready_n = 1'b0;
               st_nxt.data = i_rd_data;
               st_nxt.store = ~i_host_req.read;
            end
         end
         HHT_DONE: begin
            // Host keeps strobe low until ready seen low
            if (i_host_req.strobe_n) begin
               st_nxt.ready_n = 1'b1;
               st_nxt.hs = HHT_IDLE;
            end
         end
         HHT_RELEASE: begin
            st_nxt.ready_n = 1'b1;
            if (i_host_req.strobe_n) begin
               st_nxt.hs = HHT_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= '{hs: HHT_IDLE, cnt: '0, ready_n: RST_READY, io_buffer_enable_out_n: RST_IO_BUFFER_ENABLE_OUT,
                   data: '0, store: 1'b0, transparent: STRAP_BUFFERED,
                   strap_taken: 1'b0, cfg1_ext_start: 1'b0, cfg1_subsystem_flag_in: 1'b0,
                   status_subsystem_flag_in: 1'b0, wtg_pending: 1'b0, trig: '0, zw: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from state flops
   assign o_host_ready_out_n = st_r.ready_n;
   assign o_io_buffer_enable_out_n = st_r.io_buffer_enable_out_n;
   assign o_host_data = st_r.data;
   assign o_store_strobe = st_r.store;
   assign o_transparent = st_r.transparent;
   assign o_cfg1_subsystem_flag_in = st_r.cfg1_subsystem_flag_in;
   assign o_status_subsystem_flag_in = st_r.status_subsystem_flag_in;
   assign o_trig = st_r.trig;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_rt_flag;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_mode == HHT_MODE_RT && !i_subsystem_flag_in_n) |=> o_status_subsystem_flag_in;
   endproperty
   a_rt_flag: assert property (p_rt_flag) else $error("status flag not set");

   property p_cfg_readback;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!i_cfg1_wr && $past(i_cfg1_wr) == 1'b0) |=> $stable(o_cfg1_subsystem_flag_in);
   endproperty
   a_cfg_readback: assert property (p_cfg_readback) else $error("bit 8 changed without write");

   property p_bc_start;
      @(posedge i_clk) disable iff (!i_reset_n)
      o_trig.bc_start |-> $past(i_mode == HHT_MODE_BC) && $past(trig_level, 2) && !$past(trig_level, 3);
   endproperty
   a_bc_start: assert property (p_bc_start) else $error("bc start without edge");

   property p_wtg;
      @(posedge i_clk) disable iff (!i_reset_n)
      o_trig.wtg_advance |-> $past(trig_rise) && $past(i_wait_trigger_instr);
   endproperty
   a_wtg: assert property (p_wtg) else $error("advance without trigger");

   property p_mon_start;
      @(posedge i_clk) disable iff (!i_reset_n)
      o_trig.mon_start |-> $past(i_mode == HHT_MODE_WORD_MON) && $past(st_r.cfg1_ext_start);
   endproperty
   a_mon_start: assert property (p_mon_start) else $error("monitor start wrong");

   property p_msg_mon;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_mode == HHT_MODE_MSG_MON) |=> (o_trig == '0);
   endproperty
   a_msg_mon: assert property (p_msg_mon) else $error("trigger acted in message monitor");

   property p_ready_nzw;
      @(posedge i_clk) disable iff (!i_reset_n)
      (st_r.hs == HHT_IDLE && !i_host_req.strobe_n && (!i_host_req.zero_wait || st_r.transparent))
      |=> o_host_ready_out_n ##ACCESS_CNT !o_host_ready_out_n;
   endproperty
   a_ready_nzw: assert property (p_ready_nzw) else $error("ready timing wrong");

   property p_ready_release;
      @(posedge i_clk) disable iff (!i_reset_n)
      (st_r.hs == HHT_DONE && i_host_req.strobe_n) |=> o_host_ready_out_n;
   endproperty
   a_ready_release: assert property (p_ready_release) else $error("ready stuck low");

   property p_io_buffer_enable_out;
      @(posedge i_clk) disable iff (!i_reset_n)
      !o_io_buffer_enable_out_n |-> (st_r.hs == HHT_ACCESS);
   endproperty
   a_io_buffer_enable_out: assert property (p_io_buffer_enable_out) else $error("io enable low outside access");
endmodule : hht_host_ctrl
`default_nettype wire

// ==== verif/hht_host_model.sv ====
// Host processor model: runs one strobe handshake per go request.
// Assumes the bench raises go only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module hht_host_model
   import hht_pkg::*;
(
   input wire logic i_clk,           // Clock
   input wire logic i_go,            // Start one transfer
   input wire logic i_read,          // Direction
   input wire logic i_zero_wait,     // Wait mode
   input wire logic i_ready_n,       // Ready from block
   input wire logic i_io_buffer_enable_out_n,        // I/O enable from block
   output var hht_host_req_t o_req,  // Request to block
   output logic o_busy,              // Transfer running
   output logic o_saw_io_buffer_enable_out,          // I/O enable seen low
   output var int o_n_acc,           // Negedges until ready low
   output var int o_n_rel            // Negedges until ready high
);
   ////////////////////////////////////////////////////////////////////////
   // Strobe handshake, host side
   initial begin
      o_req = '{1'h1, 1'h0, 1'h0};
      o_busy = 1'h0;
      o_saw_io_buffer_enable_out = 1'h0;
      o_n_acc = 0;
      o_n_rel = 0;
      forever begin
         @(posedge i_clk iff i_go);
         @(negedge i_clk);
         o_busy = 1'h1;
         o_saw_io_buffer_enable_out = 1'h0;
         o_n_acc = 0;
         o_n_rel = 0;
         o_req = '{1'h0, i_read, i_zero_wait};
         // Strobe held low until ready is seen low
         do begin
            @(negedge i_clk);
            o_n_acc++;
            o_saw_io_buffer_enable_out |= ~i_io_buffer_enable_out_n;
         end while (i_ready_n);
         o_req.strobe_n = 1'h1;
         do begin
            @(negedge i_clk);
            o_n_rel++;
         end while (i_ready_n == 1'h0);
         o_busy = 1'h0;
      end
   end
endmodule : hht_host_model
`default_nettype wire

// ==== verif/tb.sv ====
// Testbench for the host handshake and trigger control block.
// Assumes the host model drives the request bundle.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import hht_pkg::*;
   localparam int ACC = 3;
   localparam int ZWB = 2;
   logic clk, rst_n, strap, go, rd, zw, cfg_wr, flag_n, wti, busy, saw_io_buffer_enable_out;
   logic ready_n, io_buffer_enable_out_n, store, transp, cfg_ss, stat_ss;
   logic [15:0] rd_data, cfg_data, host_data;
   hht_mode_t mode;
   hht_host_req_t req;
   hht_trig_t trig;
   int mismatches, tests_run, stores, n_acc, n_rel;
   ////////////////////////////////////////////////////////////////////////
   // Block and host model
   hht_host_ctrl #(.ACCESS_CNT(ACC), .ZW_BUSY_CNT(ZWB)) i_hht_host_ctrl (.i_clk(clk), .i_reset_n(rst_n),
      .i_host_port_mode_strap(strap), .i_host_req(req), .i_rd_data(rd_data), .i_mode(mode),
      .i_cfg1_wr_data(cfg_data), .i_cfg1_wr(cfg_wr), .i_subsystem_flag_in_n(flag_n),
      .i_wait_trigger_instr(wti), .o_host_ready_out_n(ready_n), .o_io_buffer_enable_out_n(io_buffer_enable_out_n),
      .o_host_data(host_data), .o_store_strobe(store), .o_transparent(transp),
      .o_cfg1_subsystem_flag_in(cfg_ss), .o_status_subsystem_flag_in(stat_ss), .o_trig(trig));
   hht_host_model i_hht_host_model (.i_clk(clk), .i_go(go), .i_read(rd), .i_zero_wait(zw),
      .i_ready_n(ready_n), .i_io_buffer_enable_out_n(io_buffer_enable_out_n), .o_req(req), .o_busy(busy), .o_saw_io_buffer_enable_out(saw_io_buffer_enable_out),
      .o_n_acc(n_acc), .o_n_rel(n_rel));
   ////////////////////////////////////////////////////////////////////////
   // Clock, store pulse counter, watchdog
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) if (store) stores++;
   initial begin
      repeat (4000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic do_reset(logic s);
      rst_n = 1'h0;
      strap = s;
      repeat (6) @(negedge clk);
      rst_n = 1'h1;
      repeat (2) @(negedge clk);
   endtask : do_reset
   task automatic cfg_w(logic [15:0] d);
      @(negedge clk);
      cfg_data = d;
      cfg_wr = 1'h1;
      @(negedge clk);
      cfg_wr = 1'h0;
   endtask : cfg_w
   task automatic xfer(logic r, logic z, int acc_exp, int rel_exp);
      int s0;
      s0 = stores;
      @(negedge clk);
      rd = r;
      zw = z;
      go = 1'h1;
      @(negedge clk);
      go = 1'h0;
      @(negedge clk);
      while (busy) @(posedge clk);
      @(negedge clk);
      check("ready delay", 16'(acc_exp), 16'(n_acc));
      if (rel_exp > 0) check("ready release", 16'(rel_exp), 16'(n_rel));
      check("io enable", 16'h1, 16'(saw_io_buffer_enable_out));
      check("io enable idle", 16'h1, 16'(io_buffer_enable_out_n));
      check("ready idle", 16'h1, 16'(ready_n));
      if (r) check("read data", rd_data, host_data);
      else check("stores", 16'(s0 + 1), 16'(stores));
   endtask : xfer
   task automatic trig_case(hht_mode_t m, logic b7, logic w, logic [2:0] exp);
      logic [2:0] seen;
      seen = 3'h0;
      mode = m;
      wti = w;
      cfg_w(16'(b7) << CFG1_EXT_START_BIT);
      flag_n = 1'h0;
      repeat (3) @(negedge clk);
      flag_n = 1'h1;
      repeat (5) begin
         @(negedge clk);
         seen = seen | trig;
      end
      check("trigger", 16'(exp), 16'(seen));
   endtask : trig_case
   task automatic flag_case(hht_mode_t m, logic b8, logic pin, logic e_cfg, logic e_st);
      mode = m;
      cfg_w(16'(b8) << CFG1_SUBSYSTEM_FLAG_IN_BIT);
      flag_n = pin;
      repeat (3) @(negedge clk);
      check("cfg flag", 16'(e_cfg), 16'(cfg_ss));
      check("status flag", 16'(e_st), 16'(stat_ss));
   endtask : flag_case
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_buffered();
      do_reset(STRAP_BUFFERED);
      check("transparent", 16'h0, 16'(transp));
      xfer(1'h1, 1'h0, ACC + 1, 1);
      rd_data = 16'h5a3c;
      xfer(1'h1, 1'h0, ACC + 1, 1);
      xfer(1'h0, 1'h0, ACC + 1, 1);
      xfer(1'h1, 1'h1, 1, ZWB + 1);
      xfer(1'h0, 1'h1, 1, ZWB + 1);
      $display("test buffered done");
   endtask : test_buffered
   task automatic test_transparent();
      do_reset(STRAP_TRANSPARENT);
      check("transparent", 16'h1, 16'(transp));
      xfer(1'h1, 1'h1, ACC + 1, 1);
      xfer(1'h0, 1'h1, ACC + 1, 1);
      $display("test transparent done");
   endtask : test_transparent
   task automatic test_triggers();
      trig_case(HHT_MODE_BC, 1'h1, 1'h0, 3'h4);
      trig_case(HHT_MODE_BC, 1'h0, 1'h0, 3'h0);
      trig_case(HHT_MODE_BC_ENH, 1'h0, 1'h1, 3'h2);
      trig_case(HHT_MODE_BC_ENH, 1'h1, 1'h0, 3'h0);
      trig_case(HHT_MODE_WORD_MON, 1'h1, 1'h0, 3'h1);
      trig_case(HHT_MODE_WORD_MON, 1'h0, 1'h0, 3'h0);
      trig_case(HHT_MODE_MSG_MON, 1'h1, 1'h1, 3'h0);
      trig_case(HHT_MODE_RT, 1'h1, 1'h1, 3'h0);
      $display("test triggers done");
   endtask : test_triggers
   task automatic test_flag();
      flag_case(HHT_MODE_RT, 1'h0, 1'h1, 1'h0, 1'h1);
      flag_case(HHT_MODE_RT, 1'h0, 1'h0, 1'h0, 1'h1);
      flag_case(HHT_MODE_RT, 1'h1, 1'h0, 1'h1, 1'h1);
      flag_case(HHT_MODE_RT, 1'h1, 1'h1, 1'h1, 1'h0);
      flag_case(HHT_MODE_MSG_MON, 1'h1, 1'h0, 1'h1, 1'h0);
      $display("test flag done");
   endtask : test_flag
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst_n, strap, go, rd, zw, cfg_wr, wti} = 7'h0;
      flag_n = 1'h1;
      rd_data = 16'ha5c3;
      cfg_data = 16'h0;
      mode = HHT_MODE_RT;
      test_buffered();
      test_transparent();
      test_triggers();
      test_flag();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
